// file: inc/t1lan_pkg.sv
// Constants shared by the negotiation and coding status register bank.
// Assumes a flat 16-bit register address space on a simple strobe port.
package t1lan_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [15:0] OFF_PKG1     = 16'h0005;
   localparam logic [15:0] OFF_PKG2     = 16'h0006;
   localparam logic [15:0] OFF_CTRL     = 16'h0200;
   localparam logic [15:0] OFF_STATUS   = 16'h0201;
   localparam logic [15:0] OFF_PCS_STAT = 16'h08E7;

   // ------------------------------------------------------------
   // Fixed words and reset values
   // ------------------------------------------------------------
   localparam logic [15:0] PKG1_VALUE   = 16'h008B;
   localparam logic [15:0] PKG2_VALUE   = 16'hC000;
   localparam logic [15:0] CTRL_RESET   = 16'h1000;
   localparam logic [15:0] STATUS_RESET = 16'h0008;
   localparam logic [15:0] PCS_RESET    = 16'h0000;
   localparam logic        EN_RESET     = 1'b1;
   localparam logic        FLAG_RESET   = 1'b0;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int unsigned BIT_EN      = 12;
   localparam int unsigned BIT_RESTART = 9;
   localparam int unsigned BIT_PAGE    = 6;
   localparam int unsigned BIT_DONE    = 5;
   localparam int unsigned BIT_FAULT   = 4;
   localparam int unsigned BIT_ABLE    = 3;
   localparam int unsigned BIT_LINK    = 2;
   localparam int unsigned BIT_DSCR    = 2;

   // ------------------------------------------------------------
   // Latched flag table
   // ------------------------------------------------------------
   localparam int unsigned FLAG_DSCR  = 0;
   localparam int unsigned FLAG_PAGE  = 1;
   localparam int unsigned FLAG_FAULT = 2;
   localparam int unsigned FLAG_LINK  = 3;
   localparam int unsigned NUM_FLAGS  = 4;
   // One bit per flag: 1 latches high, 0 latches low
   localparam logic [3:0]  FLAG_LATCH_HIGH = 4'h6;

   // ------------------------------------------------------------
   // Restart handshake states
   // ------------------------------------------------------------
   typedef enum logic [1:0]
   {
      RS_IDLE = 2'b01,
      RS_PEND = 2'b10
   } t1lan_rst_state_t;

endpackage

// file: hdl/t1lan_latch_flag.sv
// One latched status flag, latch-high or latch-low by parameter.
// Assumes the read strobe is a single-cycle pulse from the bus port.
module t1lan_latch_flag #(
   parameter logic LATCH_HIGH = 1'b0
) (
   input  wire logic core_clk_i,
   input  wire logic nrst_i,
   input  wire logic live_i,
   input  wire logic read_i,
   output logic      flag_o
);

   logic next_flag;

   // ------------------------------------------------------------
   // Flag update
   // ------------------------------------------------------------
   // Read reloads the live condition, so an event in the read cycle wins
   always_comb
   begin
      if (read_i)
      begin
         next_flag = live_i;
      end
      else if (LATCH_HIGH)
      begin
         next_flag = flag_o | live_i;
      end
      else
      begin
         next_flag = flag_o & live_i;
      end
   end

   // Flag register
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         flag_o <= t1lan_pkg::FLAG_RESET;
      end
      else
      begin
         flag_o <= next_flag;
      end
   end

endmodule

// file: hdl/t1lan_restart_ctl.sv
// Self-clearing negotiation restart request.
// Assumes the negotiation engine pulses initiated_i when it restarts.
module t1lan_restart_ctl (
   input  wire logic core_clk_i,
   input  wire logic nrst_i,
   input  wire logic request_i,
   input  wire logic initiated_i,
   output logic      pending_o
);

   t1lan_pkg::t1lan_rst_state_t state;
   t1lan_pkg::t1lan_rst_state_t next_state;

   // ------------------------------------------------------------
   // Handshake state machine
   // ------------------------------------------------------------
   // A new request in the acknowledge cycle keeps the request pending
   always_comb
   begin
      case (state)
         t1lan_pkg::RS_IDLE:
         begin
            next_state = request_i ? t1lan_pkg::RS_PEND : t1lan_pkg::RS_IDLE;
         end
         t1lan_pkg::RS_PEND:
         begin
            if (initiated_i && !request_i)
            begin
               next_state = t1lan_pkg::RS_IDLE;
            end
            else
            begin
               next_state = t1lan_pkg::RS_PEND;
            end
         end
         default:
         begin
            next_state = t1lan_pkg::RS_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state <= t1lan_pkg::RS_IDLE;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign pending_o = state[1]; // Pending state bit

endmodule

// file: hdl/t1lan_regs.sv
// Negotiation control/status and coding sublayer status register bank.
// Assumes a strobe register port with read data one cycle after the strobe,
// and live status inputs synchronous to core_clk_i.
module t1lan_regs (
   input  wire logic        core_clk_i,
   input  wire logic        nrst_i,
   input  wire logic [15:0] reg_addr_i,
   input  wire logic [15:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   input  wire logic        dscr_locked_i,
   input  wire logic        link_ok_i,
   input  wire logic        page_stored_i,
   input  wire logic        base_fault_i,
   input  wire logic        neg_finished_i,
   input  wire logic        restart_initiated_i,
   output logic [15:0]      reg_rdata_o,
   output logic             negotiation_enable_o,
   output logic             negotiation_restart_o
);

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   logic        rd_status;
   logic        rd_pcs;
   logic        wr_ctrl;
   logic        write_restart;
   logic [3:0]  flag_live;
   logic [3:0]  flag_read;
   logic [3:0]  flag_q;
   logic        negotiation_done;
   logic        next_done;
   logic        next_enable;
   logic [15:0] next_rdata;
   logic [15:0] ctrl_word;
   logic [15:0] status_word;
   logic [15:0] pcs_word;

   // Strobe qualification per register
   assign rd_status     = reg_rd_i && (reg_addr_i == t1lan_pkg::OFF_STATUS);
   assign rd_pcs        = reg_rd_i && (reg_addr_i == t1lan_pkg::OFF_PCS_STAT);
   assign wr_ctrl       = reg_wr_i && (reg_addr_i == t1lan_pkg::OFF_CTRL);
   assign write_restart = wr_ctrl && reg_wdata_i[t1lan_pkg::BIT_RESTART];

   // ------------------------------------------------------------
   // Latched flags
   // ------------------------------------------------------------
   // Live conditions and the read that reloads each flag
   always_comb
   begin
      flag_live                        = '0;
      flag_read                        = '0;
      flag_live[t1lan_pkg::FLAG_DSCR]  = dscr_locked_i;
      flag_live[t1lan_pkg::FLAG_PAGE]  = page_stored_i;
      flag_live[t1lan_pkg::FLAG_FAULT] = base_fault_i;
      flag_live[t1lan_pkg::FLAG_LINK]  = link_ok_i;
      flag_read[t1lan_pkg::FLAG_DSCR]  = rd_pcs;
      flag_read[t1lan_pkg::FLAG_PAGE]  = rd_status;
      flag_read[t1lan_pkg::FLAG_FAULT] = rd_status;
      flag_read[t1lan_pkg::FLAG_LINK]  = rd_status;
   end

   // One latch cell per flag
   for (genvar i = 0; i < t1lan_pkg::NUM_FLAGS; i++)
   begin : g_flag
      t1lan_latch_flag #(
         .LATCH_HIGH (t1lan_pkg::FLAG_LATCH_HIGH[i])
      ) u_flag (
         .core_clk_i (core_clk_i),
         .nrst_i     (nrst_i),
         .live_i     (flag_live[i]),
         .read_i     (flag_read[i]),
         .flag_o     (flag_q[i])
      );
   end

   // ------------------------------------------------------------
   // Restart request
   // ------------------------------------------------------------
   t1lan_restart_ctl u_restart (
      .core_clk_i  (core_clk_i),
      .nrst_i      (nrst_i),
      .request_i   (write_restart),
      .initiated_i (restart_initiated_i),
      .pending_o   (negotiation_restart_o)
   );

   // ------------------------------------------------------------
   // Control and status next values
   // ------------------------------------------------------------
   // Enable bit is written from the control word only
   always_comb
   begin
      next_enable = negotiation_enable_o;
      if (wr_ctrl)
      begin
         next_enable = reg_wdata_i[t1lan_pkg::BIT_EN];
      end
      next_done = neg_finished_i && link_ok_i;
   end

   // Control and done registers
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         negotiation_enable_o <= t1lan_pkg::EN_RESET;
         negotiation_done     <= 1'b0;
      end
      else
      begin
         negotiation_enable_o <= next_enable;
         negotiation_done     <= next_done;
      end
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   // Register images, unlisted bits read as zero
   always_comb
   begin
      ctrl_word                          = '0;
      ctrl_word[t1lan_pkg::BIT_EN]       = negotiation_enable_o;
      ctrl_word[t1lan_pkg::BIT_RESTART]  = negotiation_restart_o;
      status_word                        = '0;
      status_word[t1lan_pkg::BIT_PAGE]   = flag_q[t1lan_pkg::FLAG_PAGE];
      status_word[t1lan_pkg::BIT_DONE]   = negotiation_done;
      status_word[t1lan_pkg::BIT_FAULT]  = flag_q[t1lan_pkg::FLAG_FAULT];
      status_word[t1lan_pkg::BIT_ABLE]   = 1'b1;
      status_word[t1lan_pkg::BIT_LINK]   = flag_q[t1lan_pkg::FLAG_LINK];
      pcs_word                           = '0;
      pcs_word[t1lan_pkg::BIT_DSCR]      = flag_q[t1lan_pkg::FLAG_DSCR];
   end

   // Read mux, zero outside a read and on unmapped addresses
   always_comb
   begin
      next_rdata = '0;
      if (reg_rd_i)
      begin
         case (reg_addr_i)
            t1lan_pkg::OFF_PKG1:     next_rdata = t1lan_pkg::PKG1_VALUE;
            t1lan_pkg::OFF_PKG2:     next_rdata = t1lan_pkg::PKG2_VALUE;
            t1lan_pkg::OFF_CTRL:     next_rdata = ctrl_word;
            t1lan_pkg::OFF_STATUS:   next_rdata = status_word;
            t1lan_pkg::OFF_PCS_STAT: next_rdata = pcs_word;
            default:                 next_rdata = '0;
         endcase
      end
   end

   // Read data register
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         reg_rdata_o <= '0;
      end
      else
      begin
         reg_rdata_o <= next_rdata;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!nrst_i);

   // Named steps of the status read and restart acknowledge sequences
   sequence s_quiet_status;
      !rd_status && !page_stored_i;
   endsequence

   sequence s_link_lost_then_read;
      (!link_ok_i && !rd_status) ##1 !rd_status ##1 rd_status;
   endsequence

   sequence s_fault_then_read;
      base_fault_i ##1 !rd_status ##1 rd_status;
   endsequence

   sequence s_restart_ack;
      negotiation_restart_o && restart_initiated_i && !write_restart;
   endsequence

   chk_dscr_low: assert property (
      (!dscr_locked_i && !rd_pcs) ##1 !rd_pcs ##1 rd_pcs |=>
         !reg_rdata_o[t1lan_pkg::BIT_DSCR])
      else $error("descrambler loss not reported");

   chk_pcs_reserved: assert property (
      rd_pcs |=> reg_rdata_o[15:3] == 13'h0000 &&
         reg_rdata_o[1:0] == 2'h0)
      else $error("coding status reserved bits not zero");

   chk_pkg1_value: assert property (
      reg_rd_i && reg_addr_i == t1lan_pkg::OFF_PKG1 |=>
         reg_rdata_o == t1lan_pkg::PKG1_VALUE)
      else $error("package word 1 wrong");

   chk_pkg2_value: assert property (
      reg_rd_i && reg_addr_i == t1lan_pkg::OFF_PKG2 |=>
         reg_rdata_o == t1lan_pkg::PKG2_VALUE)
      else $error("package word 2 wrong");

   chk_enable_write: assert property (
      wr_ctrl ##1 !reg_wr_i ##1
         (reg_rd_i && reg_addr_i == t1lan_pkg::OFF_CTRL) |=>
         reg_rdata_o[t1lan_pkg::BIT_EN] ==
            $past(reg_wdata_i[t1lan_pkg::BIT_EN], 3))
      else $error("enable bit not written");

   chk_enable_hold: assert property (
      !wr_ctrl |=> $stable(negotiation_enable_o))
      else $error("enable bit changed without write");

   chk_ctrl_reserved: assert property (
      reg_rd_i && reg_addr_i == t1lan_pkg::OFF_CTRL |=>
         reg_rdata_o[15:13] == 3'h0 && reg_rdata_o[11:10] == 2'h0 &&
            reg_rdata_o[8:0] == 9'h000)
      else $error("control reserved bits not zero");

   chk_restart_set: assert property (
      write_restart |=> negotiation_restart_o)
      else $error("restart bit not set by write");

   chk_restart_hold: assert property (
      negotiation_restart_o && !restart_initiated_i |=>
         negotiation_restart_o)
      else $error("restart bit dropped early");

   chk_restart_clear: assert property (
      s_restart_ack |=> !negotiation_restart_o)
      else $error("restart bit not self cleared");

   chk_page_set: assert property (
      page_stored_i ##1 !rd_status ##1 rd_status |=>
         reg_rdata_o[t1lan_pkg::BIT_PAGE])
      else $error("page flag not set");

   chk_page_clear: assert property (
      (rd_status && !page_stored_i) ##1 !page_stored_i ##1
         (rd_status && !page_stored_i) |=>
         !reg_rdata_o[t1lan_pkg::BIT_PAGE])
      else $error("page flag not cleared by read");

   chk_page_cause: assert property (
      $rose(flag_q[t1lan_pkg::FLAG_PAGE]) |-> $past(page_stored_i))
      else $error("page flag rose without stored page");

   chk_done_follow: assert property (
      (neg_finished_i && link_ok_i) ##1 rd_status |=>
         reg_rdata_o[t1lan_pkg::BIT_DONE])
      else $error("done bit not set");

   chk_done_clear: assert property (
      (!neg_finished_i || !link_ok_i) ##1 rd_status |=>
         !reg_rdata_o[t1lan_pkg::BIT_DONE])
      else $error("done bit set without finish and link");

   chk_fault_hold: assert property (
      s_fault_then_read |=> reg_rdata_o[t1lan_pkg::BIT_FAULT])
      else $error("remote fault flag lost");

   chk_fault_set: assert property (
      base_fault_i |=> flag_q[t1lan_pkg::FLAG_FAULT])
      else $error("remote fault flag not latched");

   chk_able_one: assert property (
      rd_status |=> reg_rdata_o[t1lan_pkg::BIT_ABLE])
      else $error("capable bit not set");

   chk_status_reserved: assert property (
      rd_status |=> reg_rdata_o[15:7] == 9'h000 &&
         reg_rdata_o[1:0] == 2'h0)
      else $error("status reserved bits not zero");

   chk_link_low: assert property (
      s_link_lost_then_read |=> !reg_rdata_o[t1lan_pkg::BIT_LINK])
      else $error("link loss not reported");

   chk_link_reload: assert property (
      (rd_status && link_ok_i) ##1 link_ok_i ##1 (rd_status && link_ok_i) |=>
         reg_rdata_o[t1lan_pkg::BIT_LINK])
      else $error("link flag not reloaded after read");

   chk_quiet_page: assert property (
      rd_status ##1 s_quiet_status ##1 rd_status |=>
         !reg_rdata_o[t1lan_pkg::BIT_PAGE] ||
            $past(page_stored_i, 3))
      else $error("page flag reload wrong");

endmodule

// file: testbench/testbench.sv
// Self-checking bench for the negotiation and coding status register bank.
// Assumes the design package is compiled first; the bench drives all ports.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   // ---------------------------------------------------------------
   // Signals and counters
   // ---------------------------------------------------------------
   logic        core_clk_i;
   logic        nrst_i;
   logic [15:0] reg_addr_i;
   logic [15:0] reg_wdata_i;
   logic        reg_wr_i;
   logic        reg_rd_i;
   logic        dscr_locked_i;
   logic        link_ok_i;
   logic        page_stored_i;
   logic        base_fault_i;
   logic        neg_finished_i;
   logic        restart_initiated_i;
   logic [15:0] reg_rdata_o;
   logic        negotiation_enable_o;
   logic        negotiation_restart_o;
   int          miscompares;
   int          tests_run;
   logic        en;
   logic        pend;
   logic [31:0] r;
   logic [15:0] a;

   t1lan_regs dut (
      .core_clk_i            (core_clk_i),
      .nrst_i                (nrst_i),
      .reg_addr_i            (reg_addr_i),
      .reg_wdata_i           (reg_wdata_i),
      .reg_wr_i              (reg_wr_i),
      .reg_rd_i              (reg_rd_i),
      .dscr_locked_i         (dscr_locked_i),
      .link_ok_i             (link_ok_i),
      .page_stored_i         (page_stored_i),
      .base_fault_i          (base_fault_i),
      .neg_finished_i        (neg_finished_i),
      .restart_initiated_i   (restart_initiated_i),
      .reg_rdata_o           (reg_rdata_o),
      .negotiation_enable_o  (negotiation_enable_o),
      .negotiation_restart_o (negotiation_restart_o)
   );

   // ---------------------------------------------------------------
   // Clock and watchdog
   // ---------------------------------------------------------------
   initial
   begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end

   initial
   begin
      #200000;
      miscompares++;
      complete_run();
   end

   // ---------------------------------------------------------------
   // Expected words and compare tasks
   // ---------------------------------------------------------------
   function automatic logic [15:0] stat(logic p, logic d, logic f, logic l);
      return {9'h000, p, d, f, 1'b1, l, 2'h0};
   endfunction

   function automatic logic [15:0] ctl(logic e, logic s);
      return {3'h0, e, 2'h0, s, 9'h000};
   endfunction

   function automatic logic [15:0] fixed(logic [15:0] ad, logic e, logic s);
      if (ad == t1lan_pkg::OFF_PKG1)
         return 16'h008B;
      if (ad == t1lan_pkg::OFF_PKG2)
         return 16'hC000;
      if (ad == t1lan_pkg::OFF_CTRL)
         return ctl(e, s);
      return 16'h0000;
   endfunction

   task automatic chk16(input string n, input logic [15:0] e,
                        input logic [15:0] g);
      tests_run++;
      if (g !== e)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk1(input string n, input logic e, input logic g);
      tests_run++;
      if (g !== e)
      begin
         miscompares++;
         $display("MISMATCH %s expected %b seen %b", n, e, g);
      end
   endtask

   task automatic complete_run;
      if (miscompares == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Register port and live input drivers
   // ---------------------------------------------------------------
   task automatic wr(input logic [15:0] ad, input logic [15:0] d);
      @(posedge core_clk_i);
      reg_addr_i  <= ad;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_i    <= 1'b0;
      #1;
   endtask

   task automatic rdck(input logic [15:0] ad, input logic [15:0] e);
      @(posedge core_clk_i);
      reg_addr_i <= ad;
      reg_rd_i   <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_i   <= 1'b0;
      #1;
      chk16("read data", e, reg_rdata_o);
   endtask

   // One-cycle event: 0 page, 1 fault, 2 link drop, 3 lock drop, 4 ack
   task automatic blip(input int s);
      @(posedge core_clk_i);
      case (s)
         0: page_stored_i <= 1'b1;
         1: base_fault_i <= 1'b1;
         2: link_ok_i <= 1'b0;
         3: dscr_locked_i <= 1'b0;
         default: restart_initiated_i <= 1'b1;
      endcase
      @(posedge core_clk_i);
      page_stored_i       <= 1'b0;
      base_fault_i        <= 1'b0;
      restart_initiated_i <= 1'b0;
      link_ok_i           <= 1'b1;
      dscr_locked_i       <= 1'b1;
   endtask

   // Bounded wait for the restart request to drop
   task automatic wait_restart_low;
      for (int i = 0; i < 4; i++)
      begin
         @(posedge core_clk_i);
         #1;
         if (negotiation_restart_o === 1'b0)
            return;
      end
      miscompares++;
      $display("MISMATCH restart_drop expected 0 seen 1");
      complete_run();
   endtask

   task automatic do_reset;
      @(posedge core_clk_i);
      nrst_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      #1;
      chk1("enable", 1'b1, negotiation_enable_o);
      chk1("restart", 1'b0, negotiation_restart_o);
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      {reg_addr_i, reg_wdata_i} = 32'h0000_0000;
      {reg_wr_i, reg_rd_i, dscr_locked_i, link_ok_i} = 4'h0;
      {page_stored_i, base_fault_i, neg_finished_i} = 3'h0;
      restart_initiated_i = 1'b0;
      nrst_i = 1'b0;
      miscompares = 0;
      tests_run = 0;
      void'($urandom(32'hA5B47E77));
      do_reset();
      rdck(t1lan_pkg::OFF_PKG1, 16'h008B);
      rdck(t1lan_pkg::OFF_PKG2, 16'hC000);
      rdck(t1lan_pkg::OFF_CTRL, 16'h1000);
      rdck(t1lan_pkg::OFF_STATUS, 16'h0008);
      rdck(t1lan_pkg::OFF_PCS_STAT, 16'h0000);
      rdck(16'h0007, 16'h0000);
      wr(t1lan_pkg::OFF_PKG1, 16'hFFFF);
      rdck(t1lan_pkg::OFF_PKG1, 16'h008B);
      // Latched-low link and lock flags
      @(posedge core_clk_i);
      link_ok_i     <= 1'b1;
      dscr_locked_i <= 1'b1;
      rdck(t1lan_pkg::OFF_STATUS, stat(0, 0, 0, 0));
      rdck(t1lan_pkg::OFF_STATUS, stat(0, 0, 0, 1));
      blip(2);
      rdck(t1lan_pkg::OFF_STATUS, stat(0, 0, 0, 0));
      rdck(t1lan_pkg::OFF_STATUS, stat(0, 0, 0, 1));
      rdck(t1lan_pkg::OFF_PCS_STAT, 16'h0000);
      rdck(t1lan_pkg::OFF_PCS_STAT, 16'h0004);
      blip(3);
      rdck(t1lan_pkg::OFF_PCS_STAT, 16'h0000);
      rdck(t1lan_pkg::OFF_PCS_STAT, 16'h0004);
      // Done needs both finish and link
      @(posedge core_clk_i);
      neg_finished_i <= 1'b1;
      rdck(t1lan_pkg::OFF_STATUS, stat(0, 1, 0, 1));
      @(posedge core_clk_i);
      link_ok_i <= 1'b0;
      rdck(t1lan_pkg::OFF_STATUS, stat(0, 0, 0, 0));
      @(posedge core_clk_i);
      link_ok_i <= 1'b1;
      rdck(t1lan_pkg::OFF_STATUS, stat(0, 1, 0, 0));
      // Latched-high page and fault flags
      blip(0);
      rdck(t1lan_pkg::OFF_STATUS, stat(1, 1, 0, 1));
      rdck(t1lan_pkg::OFF_STATUS, stat(0, 1, 0, 1));
      blip(1);
      repeat (20) @(posedge core_clk_i);
      rdck(t1lan_pkg::OFF_STATUS, stat(0, 1, 1, 1));
      rdck(t1lan_pkg::OFF_STATUS, stat(0, 1, 0, 1));
      blip(1);
      rdck(t1lan_pkg::OFF_STATUS, stat(0, 1, 1, 1));
      rdck(t1lan_pkg::OFF_STATUS, stat(0, 1, 0, 1));
      blip(0);
      rdck(t1lan_pkg::OFF_PCS_STAT, 16'h0004);
      rdck(t1lan_pkg::OFF_STATUS, stat(1, 1, 0, 1));
      @(posedge core_clk_i);
      neg_finished_i <= 1'b0;
      // Restart request holds until the engine starts
      wr(t1lan_pkg::OFF_CTRL, 16'hFFFF);
      chk1("restart", 1'b1, negotiation_restart_o);
      rdck(t1lan_pkg::OFF_CTRL, ctl(1, 1));
      wr(t1lan_pkg::OFF_CTRL, 16'h1000);
      rdck(t1lan_pkg::OFF_CTRL, ctl(1, 1));
      blip(4);
      wait_restart_low();
      rdck(t1lan_pkg::OFF_CTRL, ctl(1, 0));
      // Random control writes and random address traffic
      en   = 1'b1;
      pend = 1'b0;
      for (int i = 0; i < 24; i++)
      begin
         r = $urandom;
         wr(t1lan_pkg::OFF_CTRL, r[15:0]);
         en   = r[12];
         pend = pend | r[9];
         chk1("enable", en, negotiation_enable_o);
         rdck(t1lan_pkg::OFF_CTRL, ctl(en, pend));
         a = r[31:16];
         if (r[0])
            a = {14'h0001, r[2:1]};
         if (a == t1lan_pkg::OFF_STATUS || a == t1lan_pkg::OFF_PCS_STAT)
            a = t1lan_pkg::OFF_PKG2;
         if (a != t1lan_pkg::OFF_CTRL)
            wr(a, ~r[15:0]);
         rdck(a, fixed(a, en, pend));
      end
      if (pend)
      begin
         blip(4);
         wait_restart_low();
      end
      // Disable, then a second reset brings enable back
      wr(t1lan_pkg::OFF_CTRL, 16'h0000);
      chk1("enable", 1'b0, negotiation_enable_o);
      do_reset();
      rdck(t1lan_pkg::OFF_CTRL, 16'h1000);
      rdck(t1lan_pkg::OFF_STATUS, 16'h0008);
      complete_run();
   end

endmodule
